// [rtl/gcr_global_config.sv]
// Global configuration register bank behind the index/data port pair.
// Assumes port strobes are single-cycle and synchronous to ref_clk_in,
// and that the per-device register sets answer reads in the same cycle.
`timescale 1ns/1ps
module gcr_global_config
#(
    parameter logic [7:0] CHIP_IDENTIFIER = 8'hA5,  // Arbitrary value
    parameter logic [7:0] CHIP_REVISION   = 8'h01   // Arbitrary value
)
(
    // Clock and resets
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       hard_reset_in,
    input  wire logic       standby_supply_power_on_reset_in,
    // Configuration mode
    input  wire logic       config_mode_in,
    // Index/data port
    input  wire logic       index_wr_in,
    input  wire logic       data_wr_in,
    input  wire logic       data_rd_in,
    input  wire logic [7:0] wr_data_in,
    output logic      [7:0] rd_data_out,
    output logic            rd_valid_out,
    // Per-device register sets
    output logic            dev_wr_out,
    output logic            dev_rd_out,
    output logic      [7:0] dev_index_out,
    output logic      [7:0] dev_wr_data_out,
    output logic      [7:0] dev_select_out,
    output logic            activate_wr_out,
    input  wire logic [7:0] dev_rd_data_in,
    output logic            soft_reset_pulse_out,
    // Function enables
    output logic            floppy_controller_en_out,
    output logic            game_port_en_out,
    output logic            parallel_port_en_out,
    output logic            serial_port1_en_out,
    output logic            serial_port2_en_out,
    output logic            midi_interface_en_out
);
    import gcr_pkg::*;

    typedef struct packed {
        logic [7:0] index;
        logic [7:0] ldn;
        logic [7:0] pwr;
        logic       ctrl_soft;
        logic [7:0] rd_data;
        logic       rd_valid;
    } gcr_state_s;

    gcr_state_s state_reg;
    gcr_state_s state_next;

    logic       sync_rst;
    logic       cfg_index_wr;
    logic       cfg_data_wr;
    logic       cfg_data_rd;
    logic       soft_pulse;
    logic [7:0] global_rd_data;

    // ---------------------------------------------------------------
    // Access qualification
    // ---------------------------------------------------------------
    // Outside configuration mode the ports belong to other logic, so
    // every strobe is dropped here rather than stored for later.
    assign sync_rst     = hard_reset_in | standby_supply_power_on_reset_in;
    assign cfg_index_wr = config_mode_in & index_wr_in;
    assign cfg_data_wr  = config_mode_in & data_wr_in;
    assign cfg_data_rd  = config_mode_in & data_rd_in;

    // ---------------------------------------------------------------
    // Global read multiplexer
    // ---------------------------------------------------------------
    always_comb
    begin
        global_rd_data = READ_ZERO;
        if (state_reg.index == IDX_LOGICAL_DEVICE_SELECT)
        begin
            global_rd_data = state_reg.ldn;
        end
        else if (state_reg.index == IDX_CHIP_IDENTIFIER)
        begin
            global_rd_data = CHIP_IDENTIFIER;
        end
        else if (state_reg.index == IDX_CHIP_REVISION)
        begin
            global_rd_data = CHIP_REVISION;
        end
        else if (state_reg.index == IDX_FUNCTION_POWER)
        begin
            global_rd_data = state_reg.pwr & PWR_IMPLEMENTED_MASK;
        end
    end

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        state_next           = state_reg;
        state_next.rd_valid  = 1'b0;
        state_next.ctrl_soft = 1'b0;
        if (cfg_index_wr)
        begin
            state_next.index = wr_data_in;
        end
        if (cfg_data_wr)
        begin
            if (state_reg.index == IDX_LOGICAL_DEVICE_SELECT)
            begin
                state_next.ldn = wr_data_in;
            end
            else if (state_reg.index == IDX_FUNCTION_POWER)
            begin
                state_next.pwr = wr_data_in & PWR_IMPLEMENTED_MASK;
            end
            else if (state_reg.index == IDX_CONFIG_CONTROL)
            begin
                state_next.ctrl_soft = wr_data_in[SOFT_RESET_BIT];
            end
        end
        if (cfg_data_rd)
        begin
            state_next.rd_valid = 1'b1;
            if (gcr_is_device_index(state_reg.index))
            begin
                state_next.rd_data = dev_rd_data_in;
            end
            else
            begin
                state_next.rd_data = global_rd_data;
            end
        end
        // Soft reset wins over a host write landing in the same cycle
        if (soft_pulse)
        begin
            state_next.ldn = LOGICAL_DEVICE_SELECT_RESET;
            state_next.pwr = FUNCTION_POWER_RESET;
        end
        if (sync_rst)
        begin
            state_next.index     = INDEX_RESET;
            state_next.ldn       = LOGICAL_DEVICE_SELECT_RESET;
            state_next.pwr       = FUNCTION_POWER_RESET;
            state_next.ctrl_soft = CONFIG_CONTROL_RESET[SOFT_RESET_BIT];
            state_next.rd_data   = READ_ZERO;
            state_next.rd_valid  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ---------------------------------------------------------------
    // Soft reset distribution
    // ---------------------------------------------------------------
    gcr_soft_reset_pulse u_soft_pulse
    (
        .ref_clk_in  (ref_clk_in),
        .rst_b_in    (rst_b_in),
        .sync_rst_in (sync_rst),
        .request_in  (state_reg.ctrl_soft),
        .pulse_out   (soft_pulse)
    );

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Write data is passed straight through; the device sets sample it
    // together with the strobe, so a flop would only add a cycle.
    assign rd_data_out          = state_reg.rd_data;
    assign rd_valid_out         = state_reg.rd_valid;
    assign dev_index_out        = state_reg.index;
    assign dev_select_out       = state_reg.ldn;
    assign dev_wr_data_out      = wr_data_in;
    assign dev_wr_out           = cfg_data_wr & gcr_is_device_index(state_reg.index);
    assign dev_rd_out           = cfg_data_rd & gcr_is_device_index(state_reg.index);
    assign activate_wr_out      = dev_wr_out & (state_reg.index == IDX_DEVICE_ACTIVATE);
    assign soft_reset_pulse_out = soft_pulse;

    assign floppy_controller_en_out = state_reg.pwr[PWR_FLOPPY_BIT];
    assign game_port_en_out         = state_reg.pwr[PWR_GAME_PORT_BIT];
    assign parallel_port_en_out     = state_reg.pwr[PWR_PARALLEL_BIT];
    assign serial_port1_en_out      = state_reg.pwr[PWR_SERIAL1_BIT];
    assign serial_port2_en_out      = state_reg.pwr[PWR_SERIAL2_BIT];
    assign midi_interface_en_out    = state_reg.pwr[PWR_MIDI_BIT];

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking gcr_cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    index_full_width_a: assert property (
        cfg_index_wr && !sync_rst |=> dev_index_out == $past(wr_data_in))
        else $error("index port did not keep all eight bits");

    unimpl_read_zero_a: assert property (
        cfg_data_rd && !sync_rst && !gcr_is_device_index(dev_index_out)
        && !gcr_is_implemented(dev_index_out) |=> rd_valid_out && rd_data_out == 8'h00)
        else $error("unimplemented index did not read zero");

    mode_gate_a: assert property (
        !config_mode_in && !soft_pulse && !sync_rst
        |-> !dev_wr_out && !dev_rd_out ##1 $stable(dev_select_out) && !rd_valid_out)
        else $error("port access acted outside configuration mode");

    soft_reset_seq_a: assert property (
        cfg_data_wr && dev_index_out == IDX_CONFIG_CONTROL && wr_data_in[SOFT_RESET_BIT]
        && !state_reg.ctrl_soft && !sync_rst ##1 !sync_rst |=> soft_reset_pulse_out)
        else $error("soft reset request did not produce a pulse two cycles later");

    ctrl_self_clear_a: assert property (
        state_reg.ctrl_soft && !cfg_data_wr |=> !state_reg.ctrl_soft)
        else $error("soft reset request bit stayed set");

    ldn_write_a: assert property (
        cfg_data_wr && dev_index_out == IDX_LOGICAL_DEVICE_SELECT && !soft_pulse && !sync_rst
        |=> dev_select_out == $past(wr_data_in))
        else $error("device select write not stored");

    activate_route_a: assert property (
        activate_wr_out == (config_mode_in && data_wr_in
        && dev_index_out == IDX_DEVICE_ACTIVATE))
        else $error("activate strobe not tied to a selected-device write");

    chip_id_read_a: assert property (
        cfg_data_rd && dev_index_out == IDX_CHIP_IDENTIFIER && !sync_rst
        |=> rd_data_out == CHIP_IDENTIFIER)
        else $error("chip identifier read wrong");

    chip_rev_read_a: assert property (
        cfg_data_rd && dev_index_out == IDX_CHIP_REVISION && !sync_rst
        |=> rd_data_out == CHIP_REVISION)
        else $error("chip revision read wrong");

    pwr_reserved_a: assert property (
        (state_reg.pwr & ~PWR_IMPLEMENTED_MASK) == 8'h00)
        else $error("reserved power bit became set");

    soft_clears_a: assert property (
        soft_reset_pulse_out |=> dev_select_out == 8'h00 && state_reg.pwr == 8'h00)
        else $error("soft reset left select or power set");

    pulse_single_a: assert property (
        soft_reset_pulse_out |=> !soft_reset_pulse_out)
        else $error("soft reset pulse longer than one cycle");

    pwr_write_a: assert property (
        cfg_data_wr && dev_index_out == IDX_FUNCTION_POWER && !soft_pulse && !sync_rst
        |=> state_reg.pwr == ($past(wr_data_in) & PWR_IMPLEMENTED_MASK))
        else $error("power control write not stored");

    enable_map_a: assert property (
        cfg_data_wr && dev_index_out == IDX_FUNCTION_POWER && !soft_pulse && !sync_rst
        |=> floppy_controller_en_out == $past(wr_data_in[PWR_FLOPPY_BIT])
        && game_port_en_out == $past(wr_data_in[PWR_GAME_PORT_BIT])
        && parallel_port_en_out == $past(wr_data_in[PWR_PARALLEL_BIT])
        && serial_port1_en_out == $past(wr_data_in[PWR_SERIAL1_BIT])
        && serial_port2_en_out == $past(wr_data_in[PWR_SERIAL2_BIT])
        && midi_interface_en_out == $past(wr_data_in[PWR_MIDI_BIT]))
        else $error("function enable did not follow its power bit");

    sync_clear_a: assert property (
        sync_rst |=> dev_index_out == 8'h00 && dev_select_out == 8'h00
        && state_reg.pwr == 8'h00 && !state_reg.ctrl_soft && !rd_valid_out
        && !soft_reset_pulse_out)
        else $error("hard or standby reset left state set");

    dev_read_route_a: assert property (
        dev_rd_out && !sync_rst |=> rd_valid_out && rd_data_out == $past(dev_rd_data_in))
        else $error("device read data not returned");

    global_local_a: assert property (
        cfg_data_wr && dev_index_out <= IDX_GLOBAL_LAST |-> !dev_wr_out && !activate_wr_out)
        else $error("global index write leaked to the device sets");

    unimpl_write_a: assert property (
        cfg_data_wr && !soft_pulse && !sync_rst && !gcr_is_device_index(dev_index_out)
        && !gcr_is_implemented(dev_index_out) |=> $stable(dev_select_out)
        && $stable(state_reg.pwr))
        else $error("write to unimplemented index changed a register");

    read_valid_a: assert property (
        !sync_rst |=> rd_valid_out == $past(cfg_data_rd))
        else $error("read valid not one cycle after the read strobe");

    index_hold_a: assert property (
        !cfg_index_wr && !sync_rst |=> $stable(dev_index_out))
        else $error("index changed without an index write");

    soft_reset_cov: cover property (soft_reset_pulse_out);
    activate_cov:   cover property (activate_wr_out);
    pwr_write_cov:  cover property (cfg_data_wr && dev_index_out == IDX_FUNCTION_POWER);
    dev_read_cov:   cover property (dev_rd_out ##1 rd_valid_out);
    sync_rst_cov:   cover property (sync_rst);

endmodule

// [rtl/gcr_pkg.sv]
// Constants, register map and decode helpers of the global configuration bank.
// Assumes one 125 MHz clock; the index/data port strobes are synchronous to it.
package gcr_pkg;

    // ---------------------------------------------------------------
    // Register indices
    // ---------------------------------------------------------------
    localparam logic [7:0] IDX_CONFIG_CONTROL        = 8'h02;
    localparam logic [7:0] IDX_LOGICAL_DEVICE_SELECT = 8'h07;
    localparam logic [7:0] IDX_CHIP_IDENTIFIER       = 8'h20;
    localparam logic [7:0] IDX_CHIP_REVISION         = 8'h21;
    localparam logic [7:0] IDX_FUNCTION_POWER        = 8'h22;
    localparam logic [7:0] IDX_GLOBAL_LAST           = 8'h2F;
    localparam logic [7:0] IDX_DEVICE_ACTIVATE       = 8'h30;

    // ---------------------------------------------------------------
    // Field positions and masks
    // ---------------------------------------------------------------
    localparam int         SOFT_RESET_BIT      = 0;
    localparam int         PWR_FLOPPY_BIT      = 0;
    localparam int         PWR_GAME_PORT_BIT   = 2;
    localparam int         PWR_PARALLEL_BIT    = 3;
    localparam int         PWR_SERIAL1_BIT     = 4;
    localparam int         PWR_SERIAL2_BIT     = 5;
    localparam int         PWR_MIDI_BIT        = 6;
    localparam logic [7:0] PWR_IMPLEMENTED_MASK = 8'h7D;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] CONFIG_CONTROL_RESET        = 8'h00;
    localparam logic [7:0] LOGICAL_DEVICE_SELECT_RESET = 8'h00;
    localparam logic [7:0] FUNCTION_POWER_RESET        = 8'h00;
    localparam logic [7:0] INDEX_RESET                 = 8'h00;
    localparam logic [7:0] READ_ZERO                   = 8'h00;

    // ---------------------------------------------------------------
    // Decode helpers
    // ---------------------------------------------------------------
    function automatic logic gcr_is_device_index(input logic [7:0] idx);
        return idx > IDX_GLOBAL_LAST;
    endfunction

    function automatic logic gcr_is_implemented(input logic [7:0] idx);
        return (idx == IDX_LOGICAL_DEVICE_SELECT) || (idx == IDX_CHIP_IDENTIFIER) ||
               (idx == IDX_CHIP_REVISION) || (idx == IDX_FUNCTION_POWER);
    endfunction

endpackage

// [rtl/gcr_soft_reset_pulse.sv]
// One-cycle soft reset pulse generator.
// Assumes the request level comes from a flip-flop in the same clock domain.
`timescale 1ns/1ps
module gcr_soft_reset_pulse
(
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_b_in,
    input  wire logic sync_rst_in,
    // Request and pulse
    input  wire logic request_in,
    output logic      pulse_out
);
    import gcr_pkg::*;

    typedef struct packed {
        logic prev;
        logic pulse;
    } gcr_pulse_s;

    gcr_pulse_s state_reg;
    gcr_pulse_s state_next;

    // ---------------------------------------------------------------
    // Edge to pulse
    // ---------------------------------------------------------------
    always_comb
    begin
        state_next       = state_reg;
        state_next.prev  = request_in;
        state_next.pulse = request_in & ~state_reg.prev;
        if (sync_rst_in)
        begin
            state_next = '0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign pulse_out = state_reg.pulse;

endmodule

// [tb/gcr_device_model.sv]
// Behavioural per-device register sets behind the forwarded device port.
// Assumes reads are answered in the strobe cycle; only Activate is stored.
`timescale 1ns/1ps
module gcr_device_model
(
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    // Device port
    input  wire logic       dev_wr_in,
    input  wire logic       dev_rd_in,
    input  wire logic [7:0] dev_index_in,
    input  wire logic [7:0] dev_wr_data_in,
    input  wire logic [7:0] dev_select_in,
    input  wire logic       activate_wr_in,
    input  wire logic       soft_reset_in,
    output logic      [7:0] dev_rd_data_out
);
    logic [7:0] act_reg [16];
    logic [7:0] junk_reg;

    // -----------------------------------------------------------
    // Storage
    // -----------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            junk_reg <= 8'h00;
            for (int i = 0; i < 16; i++)
                act_reg[i] <= 8'h00;
        end
        else
        begin
            // Changing pattern so a stale read never looks right
            junk_reg <= junk_reg + 8'h5B;
            if (soft_reset_in)
            begin
                for (int i = 0; i < 16; i++)
                    act_reg[i] <= 8'h00;
            end
            else if (activate_wr_in && dev_wr_in && dev_index_in == 8'h30)
                act_reg[dev_select_in[3:0]] <= dev_wr_data_in;
        end
    end

    // Other indices answer select and index nibbles, so routing shows
    assign dev_rd_data_out = !dev_rd_in ? junk_reg :
                             (dev_index_in == 8'h30) ? act_reg[dev_select_in[3:0]] :
                             {dev_select_in[3:0], dev_index_in[3:0]};
endmodule

// [tb/gcr_global_config_bench.sv]
// Self-checking bench of the global configuration bank.
// Assumes the bench acts as host on the index/data port, driving at falling edges.
`timescale 1ns/1ps
module gcr_global_config_bench;
    import gcr_pkg::*;

    localparam logic [7:0] ID_VAL  = 8'h3C;  // Arbitrary value
    localparam logic [7:0] REV_VAL = 8'h07;  // Arbitrary value

    logic       ref_clk_in, rst_b_in, hard_reset_in, standby_in, config_mode_in;
    logic       index_wr_in, data_wr_in, data_rd_in, rd_valid_out;
    logic [7:0] wr_data_in, rd_data_out, dev_rd_data_in, dev_index_out;
    logic [7:0] dev_wr_data_out, dev_select_out;
    logic       dev_wr_out, dev_rd_out, activate_wr_out, soft_reset_pulse_out;
    logic       fl_en, gm_en, pp_en, s1_en, s2_en, mi_en;
    logic [7:0] en_vec;
    int         mismatches, n_checks, pulses, cycles, p0;
    logic [7:0] unimpl [9] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h1F, 8'h23, 8'h2F};

    assign en_vec = {1'b0, mi_en, s2_en, s1_en, pp_en, gm_en, 1'b0, fl_en};

    // -----------------------------------------------------------
    // Instances
    // -----------------------------------------------------------
    gcr_global_config #(.CHIP_IDENTIFIER(ID_VAL), .CHIP_REVISION(REV_VAL)) u_gcr_global_config
    (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .hard_reset_in(hard_reset_in),
        .standby_supply_power_on_reset_in(standby_in), .config_mode_in(config_mode_in),
        .index_wr_in(index_wr_in), .data_wr_in(data_wr_in), .data_rd_in(data_rd_in),
        .wr_data_in(wr_data_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .dev_wr_out(dev_wr_out), .dev_rd_out(dev_rd_out), .dev_index_out(dev_index_out),
        .dev_wr_data_out(dev_wr_data_out), .dev_select_out(dev_select_out),
        .activate_wr_out(activate_wr_out), .dev_rd_data_in(dev_rd_data_in),
        .soft_reset_pulse_out(soft_reset_pulse_out), .floppy_controller_en_out(fl_en),
        .game_port_en_out(gm_en), .parallel_port_en_out(pp_en), .serial_port1_en_out(s1_en),
        .serial_port2_en_out(s2_en), .midi_interface_en_out(mi_en)
    );

    gcr_device_model u_gcr_device_model
    (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .dev_wr_in(dev_wr_out),
        .dev_rd_in(dev_rd_out), .dev_index_in(dev_index_out), .dev_wr_data_in(dev_wr_data_out),
        .dev_select_in(dev_select_out), .activate_wr_in(activate_wr_out),
        .soft_reset_in(soft_reset_pulse_out), .dev_rd_data_out(dev_rd_data_in)
    );

    // -----------------------------------------------------------
    // Clock, pulse counter and hang guard
    // -----------------------------------------------------------
    initial
    begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (soft_reset_pulse_out === 1'b1)
            pulses++;
        if (cycles == 5000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Kind 0 strobes the index port, kind 1 the data write
    task automatic strobe(input int kind, input logic [7:0] v);
        @(negedge ref_clk_in);
        wr_data_in = v;
        index_wr_in = (kind == 0);
        data_wr_in = (kind == 1);
        @(negedge ref_clk_in);
        index_wr_in = 1'b0;
        data_wr_in = 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] v);
        strobe(0, idx);
        strobe(1, v);
    endtask

    task automatic rd_check(input logic [7:0] idx, input logic [7:0] exp);
        strobe(0, idx);
        @(negedge ref_clk_in);
        data_rd_in = 1'b1;
        @(negedge ref_clk_in);
        data_rd_in = 1'b0;
        chk8((rd_valid_out === 1'b1) ? rd_data_out : 8'hXX, exp);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // -----------------------------------------------------------
    // Tests
    // -----------------------------------------------------------
    initial
    begin
        {rst_b_in, hard_reset_in, standby_in, index_wr_in, data_wr_in, data_rd_in} = '0;
        {wr_data_in, mismatches, n_checks, pulses, cycles} = '0;
        config_mode_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        rst_b_in = 1'b1;
        rd_check(8'h02, 8'h00);
        rd_check(8'h07, 8'h00);
        rd_check(8'h22, 8'h00);
        wr_reg(8'h20, 8'h00);
        wr_reg(8'h21, 8'hFF);
        rd_check(8'h20, ID_VAL);
        rd_check(8'h21, REV_VAL);
        foreach (unimpl[i])
        begin
            wr_reg(unimpl[i], 8'hFF);
            rd_check(unimpl[i], 8'h00);
        end
        for (int b = 0; b < 8; b++)
        begin
            wr_reg(8'h22, 8'h01 << b);
            rd_check(8'h22, (8'h01 << b) & 8'h7D);
            chk8(en_vec, (8'h01 << b) & 8'h7D);
        end
        // High index bits must not alias onto 0x07
        wr_reg(8'h07, 8'h05);
        wr_reg(8'h87, 8'hAA);
        rd_check(8'h07, 8'h05);
        chk8(dev_select_out, 8'h05);
        // Outside configuration mode every strobe is ignored
        strobe(0, 8'h07);
        @(negedge ref_clk_in);
        config_mode_in = 1'b0;
        strobe(0, 8'h22);
        strobe(1, 8'hFF);
        data_rd_in = 1'b1;
        @(negedge ref_clk_in);
        data_rd_in = 1'b0;
        chk8({7'h00, rd_valid_out}, 8'h00);
        config_mode_in = 1'b1;
        strobe(1, 8'h09);
        rd_check(8'h07, 8'h09);
        rd_check(8'h22, 8'h00);
        // Activate writes land only in the selected device
        for (int d = 1; d < 5; d++)
        begin
            wr_reg(8'h07, d[7:0]);
            wr_reg(8'h30, 8'h10 + d[7:0]);
        end
        for (int d = 1; d < 5; d++)
        begin
            wr_reg(8'h07, d[7:0]);
            rd_check(8'h30, 8'h10 + d[7:0]);
            rd_check(8'h60, {d[3:0], 4'h0});
        end
        // Control write without bit 0 must not reset anything
        wr_reg(8'h22, 8'h7D);
        p0 = pulses;
        wr_reg(8'h02, 8'hFE);
        repeat (3) @(negedge ref_clk_in);
        chk8(8'(pulses - p0), 8'h00);
        rd_check(8'h22, 8'h7D);
        wr_reg(8'h07, 8'h03);
        p0 = pulses;
        wr_reg(8'h02, 8'h01);
        repeat (3) @(negedge ref_clk_in);
        chk8(8'(pulses - p0), 8'h01);
        chk8(en_vec, 8'h00);
        rd_check(8'h07, 8'h00);
        rd_check(8'h22, 8'h00);
        rd_check(8'h02, 8'h00);
        rd_check(8'h20, ID_VAL);
        wr_reg(8'h07, 8'h01);
        rd_check(8'h30, 8'h00);
        // Hard and standby resets clear, with no soft pulse
        p0 = pulses;
        for (int k = 0; k < 2; k++)
        begin
            wr_reg(8'h22, 8'h7D);
            wr_reg(8'h07, 8'h06);
            @(negedge ref_clk_in);
            hard_reset_in = (k == 0);
            standby_in = (k == 1);
            @(negedge ref_clk_in);
            {hard_reset_in, standby_in} = 2'b00;
            rd_check(8'h22, 8'h00);
            rd_check(8'h07, 8'h00);
        end
        chk8(8'(pulses - p0), 8'h00);
        wrap_up();
    end
endmodule
